// *** adpc_cfg.svh ***
`ifndef ADPC_CFG_SVH
`define ADPC_CFG_SVH
// Overview of operation
// RULE_01: full-on to or from light low-power completes within 100 ms, no sample loss.
// RULE_02: full-on to or from deep low-power completes within 100 ms, samples may drop.
// RULE_03: off state powers everything down except the command listener and indicator.
// RULE_04: resume from either low-power state within 100 ms; power-up from off unbounded.
// RULE_05: full-on, deep and off always exist; light low-power is optional.
// RULE_06: light state keeps full context; deep state needs software save and restore.
// RULE_07: off goes to full-on on open from closed, or resume when paused.
// RULE_08: pause in full-on enters light if supported, otherwise deep.
// RULE_09: resume in either low-power state returns to full-on.
// RULE_10: close from full-on enters deep state and starts the inactivity timer.
// RULE_11: inactivity timer expiry in deep state moves to off.
// RULE_12: power-down in full-on during background recording goes straight to off.
// RULE_13: power-down in full-on is refused unless background recording.
// RULE_14: power-down while paused in low-power saves audio state, then goes off.
// RULE_15: pause only playback, foreground recording or duplex; never background recording.
// RULE_16: resume from pause within 100 ms without losing samples.
// RULE_17: background recording yields to foreground recording or playback.
// RULE_18: device may raise a wake event, for example on an alarm.
// RULE_19: policy owner should use an inactivity timeout against rapid open and close.
// RULE_20: power state is a two-bit code 0 to 3; inactivity timeout is a parameter.
////////////////////////////////////////////////////////////////////////////////
`define ADPC_CLK_HZ      50000000
`define ADPC_LAT_MAX_MS  100
`define ADPC_LAT_MAX_CYC (`ADPC_LAT_MAX_MS * (`ADPC_CLK_HZ / 1000))
`define ADPC_INACT_MS    1000
`define ADPC_INACT_CYC   (`ADPC_INACT_MS * (`ADPC_CLK_HZ / 1000))
`define ADPC_RST_PWR     2'h3
`define ADPC_RST_FSM     2'h0
`define ADPC_RST_FLAG    1'h0
`endif

// *** adpc_pkg.sv ***
`default_nettype none
package adpc_pkg;
    typedef enum logic [1:0] {
        ADPC_PW_FULL  = 2'b00,
        ADPC_PW_LIGHT = 2'b01,
        ADPC_PW_DEEP  = 2'b10,
        ADPC_PW_OFF   = 2'b11
    } adpc_pwr_t;
    typedef enum logic [1:0] {
        ADPC_FS_STABLE = 2'b00,
        ADPC_FS_MOVE   = 2'b01,
        ADPC_FS_SAVE   = 2'b10
    } adpc_fsm_t;
endpackage
`default_nettype wire

// *** adpc_sync.sv ***
`include "adpc_cfg.svh"
`default_nettype none
module adpc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock_i,
    input  wire logic             sys_rst_i,
    input  wire logic             clk_en_i,
    input  wire logic [WIDTH-1:0] async_i,
    output wire logic [WIDTH-1:0] sync_o
);
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic next_lvl;
        // level moves only once stages two and three agree
        always_comb begin
            next_lvl = lvl;
            if (s2 == s3) begin
                next_lvl = s2;
            end
        end
        always_ff @(posedge clock_i) begin
            if (sys_rst_i) begin
                s1  <= `ADPC_RST_FLAG;
                s2  <= `ADPC_RST_FLAG;
                s3  <= `ADPC_RST_FLAG;
                lvl <= `ADPC_RST_FLAG;
            end else if (clk_en_i) begin
                s1  <= async_i[b];
                s2  <= s1;
                s3  <= s2;
                lvl <= next_lvl;
            end
        end
        assign sync_o[b] = lvl;
    end
endmodule
`default_nettype wire

// *** adpc_timer.sv ***
`include "adpc_cfg.svh"
`default_nettype none
module adpc_timer #(
    parameter int unsigned CYC = 16
) (
    input  wire logic clock_i,
    input  wire logic sys_rst_i,
    input  wire logic clk_en_i,
    input  wire logic start_i,
    input  wire logic stop_i,
    output logic      running_o,
    output logic      expired_o
);
    localparam int W = $clog2(CYC + 1);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic         next_run;
    logic         next_exp;
    // start reloads, stop abandons, expiry is a one-cycle pulse
    always_comb begin
        next_count = count;
        next_run   = running_o;
        next_exp   = 1'b0;
        if (start_i) begin
            next_count = W'(CYC);
            next_run   = 1'b1;
        end else if (stop_i) begin
            next_run   = 1'b0;
        end else if (running_o) begin
            next_count = count - W'(1);
            if (count <= W'(1)) begin
                next_run = 1'b0;
                next_exp = 1'b1;
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            count     <= '0;
            running_o <= `ADPC_RST_FLAG;
            expired_o <= `ADPC_RST_FLAG;
        end else if (clk_en_i) begin
            count     <= next_count;
            running_o <= next_run;
            expired_o <= next_exp;
        end
    end
endmodule
`default_nettype wire

// *** adpc_ctrl.sv ***
`include "adpc_cfg.svh"
`default_nettype none
module adpc_ctrl import adpc_pkg::*; #(
    parameter bit          D1_CAP      = 1'b1,
    parameter int unsigned LAT_MAX_CYC = `ADPC_LAT_MAX_CYC,
    parameter int unsigned INACT_CYC   = `ADPC_INACT_CYC
) (
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    input  wire logic       clk_en_i,
    input  wire logic       cmd_open_i,
    input  wire logic       cmd_close_i,
    input  wire logic       cmd_pause_i,
    input  wire logic       cmd_resume_i,
    input  wire logic       cmd_pwr_down_i,
    input  wire logic       play_req_i,
    input  wire logic       rec_fg_req_i,
    input  wire logic       rec_bg_req_i,
    input  wire logic       ctx_save_ack_i,
    input  wire logic [1:0] rail_lvl_i,
    input  wire logic       alarm_i,
    input  wire logic       wake_en_i,
    output logic [1:0]      pwr_state_o,
    output logic [1:0]      pwr_req_o,
    output logic            busy_o,
    output logic            power_off_o,
    output logic            ctx_retain_o,
    output logic            ctx_lost_o,
    output logic            sample_drop_ok_o,
    output logic            ctx_save_req_o,
    output logic            open_o,
    output logic            paused_o,
    output logic            play_en_o,
    output logic            rec_fg_en_o,
    output logic            rec_bg_en_o,
    output logic            duplex_o,
    output logic            cmd_ack_o,
    output logic            cmd_reject_o,
    output logic            lat_fault_o,
    output logic            inact_run_o,
    output logic            wake_o
);
    ////////////////////////////////////////////////////////////////////////////
    adpc_fsm_t   fsm;
    adpc_fsm_t   next_fsm;
    adpc_pwr_t   cur;
    adpc_pwr_t   next_cur;
    adpc_pwr_t   tgt;
    adpc_pwr_t   next_tgt;
    adpc_pwr_t   go_to;
    logic        go_en;
    logic        bounded;
    logic        next_bounded;
    logic        next_open;
    logic        next_paused;
    logic        next_ack;
    logic        next_rej;
    logic        next_fault;
    logic        inact_start;
    logic        inact_exp;
    logic        inact_pend;
    logic        next_pend;
    logic        pend_eff;
    logic        lat_exp;
    logic        move_done;
    logic        any_cmd;
    logic        bg_live;
    logic        granted;
    logic        next_play;
    logic        next_fg;
    logic        next_bg;
    logic [1:0]  rail_lvl;
    logic [1:0]  rail_lvl_n;
    logic        alarm;
    logic        alarm_d;
    logic        next_wake;
    logic [31:0] move_age;

    ////////////////////////////////////////////////////////////////////////////
    adpc_sync #(
        .WIDTH (3)
    ) u_sync (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .clk_en_i  (clk_en_i),
        .async_i   ({alarm_i, ~rail_lvl_i}),
        .sync_o    ({alarm, rail_lvl_n})
    );
    // rail travels inverted so the cleared sync reads off
    assign rail_lvl = ~rail_lvl_n;

    adpc_timer #(
        .CYC (INACT_CYC)
    ) u_inact (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .clk_en_i  (clk_en_i),
        .start_i   (inact_start),
        .stop_i    (go_en && !inact_start),
        .running_o (inact_run_o),
        .expired_o (inact_exp)
    );

    adpc_timer #(
        .CYC (LAT_MAX_CYC)
    ) u_lat (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .clk_en_i  (clk_en_i),
        .start_i   (go_en && next_bounded),
        .stop_i    (move_done),
        .running_o (),
        .expired_o (lat_exp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // power state machine
    assign any_cmd  = cmd_open_i | cmd_close_i | cmd_pause_i | cmd_resume_i | cmd_pwr_down_i;
    assign bg_live  = rec_bg_en_o && !play_en_o && !rec_fg_en_o;
    assign pend_eff = inact_pend || inact_exp;

    always_comb begin
        next_fsm     = fsm;
        next_cur     = cur;
        next_tgt     = tgt;
        next_open    = open_o;
        next_paused  = paused_o;
        next_bounded = bounded;
        next_ack     = 1'b0;
        next_rej     = 1'b0;
        next_fault   = 1'b0;
        inact_start  = 1'b0;
        move_done    = 1'b0;
        go_en        = 1'b0;
        go_to        = cur;
        unique case (fsm)
            ADPC_FS_STABLE: begin
                if (cmd_pwr_down_i) begin
                    if (cur == ADPC_PW_FULL) begin
                        if (bg_live) begin
                            go_en    = 1'b1; // RULE_12
                            go_to    = ADPC_PW_OFF;
                            next_open = 1'b0;
                            next_ack = 1'b1;
                        end else begin
                            next_rej = 1'b1; // RULE_13
                        end
                    end else if (paused_o && cur != ADPC_PW_OFF) begin
                        next_fsm = ADPC_FS_SAVE; // RULE_14
                        next_ack = 1'b1;
                    end else if (cur == ADPC_PW_DEEP) begin
                        go_en    = 1'b1;
                        go_to    = ADPC_PW_OFF;
                        next_ack = 1'b1;
                    end else begin
                        next_rej = 1'b1;
                    end
                end else if (cmd_close_i) begin
                    if (cur == ADPC_PW_FULL && open_o && !paused_o) begin
                        go_en       = 1'b1; // RULE_10
                        go_to       = ADPC_PW_DEEP;
                        next_open   = 1'b0;
                        inact_start = 1'b1;
                        next_ack    = 1'b1;
                    end else begin
                        next_rej = 1'b1;
                    end
                end else if (cmd_pause_i) begin
                    if (cur == ADPC_PW_FULL && !paused_o && (play_en_o || rec_fg_en_o)) begin
                        go_en       = 1'b1; // RULE_15
                        go_to       = D1_CAP ? ADPC_PW_LIGHT : ADPC_PW_DEEP; // RULE_08 RULE_05
                        next_paused = 1'b1;
                        next_ack    = 1'b1;
                    end else begin
                        next_rej = 1'b1;
                    end
                end else if (cmd_resume_i) begin
                    if (paused_o && cur != ADPC_PW_FULL) begin
                        go_en       = 1'b1; // RULE_09 RULE_07
                        go_to       = ADPC_PW_FULL;
                        next_paused = 1'b0;
                        next_ack    = 1'b1;
                    end else begin
                        next_rej = 1'b1;
                    end
                end else if (cmd_open_i) begin
                    if (!open_o && !paused_o && (cur == ADPC_PW_OFF || cur == ADPC_PW_DEEP)) begin
                        go_en     = 1'b1; // RULE_07
                        go_to     = ADPC_PW_FULL;
                        next_open = 1'b1;
                        next_ack  = 1'b1;
                    end else begin
                        next_rej = 1'b1;
                    end
                end else if (pend_eff && cur == ADPC_PW_DEEP && !open_o && !paused_o) begin
                    go_en = 1'b1; // RULE_11
                    go_to = ADPC_PW_OFF;
                end
            end
            ADPC_FS_SAVE: begin
                next_rej = any_cmd;
                if (ctx_save_ack_i) begin
                    go_en = 1'b1; // RULE_14
                    go_to = ADPC_PW_OFF;
                end
            end
            ADPC_FS_MOVE: begin
                next_rej = any_cmd;
                if (rail_lvl == tgt) begin
                    move_done = 1'b1;
                end else if (lat_exp && bounded) begin
                    move_done  = 1'b1; // RULE_01 RULE_02 RULE_16
                    next_fault = 1'b1;
                end
                if (move_done) begin
                    next_cur = tgt;
                    next_fsm = ADPC_FS_STABLE;
                end
            end
            default: begin
                next_fsm = ADPC_FS_STABLE;
            end
        endcase
        if (go_en) begin
            next_fsm     = ADPC_FS_MOVE;
            next_tgt     = go_to;
            next_bounded = (go_to != ADPC_PW_OFF) && (cur != ADPC_PW_OFF); // RULE_04
        end
    end

    // expiry while still moving is held until it can act
    always_comb begin
        next_pend = inact_pend;
        if (go_en) begin
            next_pend = 1'b0;
        end
        if (inact_exp && !(go_en && go_to == ADPC_PW_OFF)) begin
            next_pend = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            fsm          <= adpc_fsm_t'(`ADPC_RST_FSM);
            cur          <= adpc_pwr_t'(`ADPC_RST_PWR);
            tgt          <= adpc_pwr_t'(`ADPC_RST_PWR);
            bounded      <= `ADPC_RST_FLAG;
            open_o       <= `ADPC_RST_FLAG;
            paused_o     <= `ADPC_RST_FLAG;
            cmd_ack_o    <= `ADPC_RST_FLAG;
            cmd_reject_o <= `ADPC_RST_FLAG;
            lat_fault_o  <= `ADPC_RST_FLAG;
            inact_pend   <= `ADPC_RST_FLAG;
        end else if (clk_en_i) begin
            fsm          <= next_fsm;
            cur          <= next_cur;
            tgt          <= next_tgt;
            bounded      <= next_bounded;
            open_o       <= next_open;
            paused_o     <= next_paused;
            cmd_ack_o    <= next_ack;
            cmd_reject_o <= next_rej;
            lat_fault_o  <= next_fault;
            inact_pend   <= next_pend;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stream grants and wake
    assign granted = open_o && !paused_o && cur == ADPC_PW_FULL && fsm == ADPC_FS_STABLE;

    always_comb begin
        next_play = granted && play_req_i;
        next_fg   = granted && rec_fg_req_i;
        next_bg   = granted && rec_bg_req_i && !play_req_i && !rec_fg_req_i; // RULE_17
        next_wake = alarm && !alarm_d && wake_en_i && cur != ADPC_PW_FULL; // RULE_18
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            play_en_o   <= `ADPC_RST_FLAG;
            rec_fg_en_o <= `ADPC_RST_FLAG;
            rec_bg_en_o <= `ADPC_RST_FLAG;
            alarm_d     <= `ADPC_RST_FLAG;
            wake_o      <= `ADPC_RST_FLAG;
        end else if (clk_en_i) begin
            play_en_o   <= next_play;
            rec_fg_en_o <= next_fg;
            rec_bg_en_o <= next_bg;
            alarm_d     <= alarm;
            wake_o      <= next_wake;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status decodes
    assign pwr_state_o      = cur; // RULE_20
    assign pwr_req_o        = tgt;
    assign busy_o           = fsm != ADPC_FS_STABLE;
    assign power_off_o      = cur == ADPC_PW_OFF; // RULE_03
    assign ctx_retain_o     = cur == ADPC_PW_LIGHT; // RULE_06
    assign ctx_lost_o       = cur == ADPC_PW_DEEP || cur == ADPC_PW_OFF; // RULE_06
    assign sample_drop_ok_o = cur == ADPC_PW_DEEP || tgt == ADPC_PW_DEEP; // RULE_02
    assign ctx_save_req_o   = fsm == ADPC_FS_SAVE;
    assign duplex_o         = play_en_o && rec_fg_en_o;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || (clk_en_i && go_en)) begin
            move_age <= '0;
        end else if (clk_en_i && fsm == ADPC_FS_MOVE && move_age != 32'hffffffff) begin
            move_age <= move_age + 32'h1;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i || !clk_en_i);

    light_latency_a: assert property ( // RULE_01
        (fsm == ADPC_FS_MOVE && bounded && (tgt == ADPC_PW_LIGHT || cur == ADPC_PW_LIGHT))
        |-> move_age <= LAT_MAX_CYC + 1) else $error("light transition too slow");
    deep_latency_a: assert property ( // RULE_02
        (fsm == ADPC_FS_MOVE && bounded && (tgt == ADPC_PW_DEEP || cur == ADPC_PW_DEEP))
        |-> move_age <= LAT_MAX_CYC + 1) else $error("deep transition too slow");
    resume_bound_a: assert property ( // RULE_04
        (fsm == ADPC_FS_MOVE && tgt == ADPC_PW_FULL && cur != ADPC_PW_OFF) |-> bounded)
        else $error("resume from low power unbounded");
    off_quiet_a: assert property ( // RULE_03
        power_off_o |-> !play_en_o && !rec_fg_en_o && !rec_bg_en_o)
        else $error("stream active while off");
    light_opt_a: assert property ( // RULE_05
        !D1_CAP |-> cur != ADPC_PW_LIGHT && tgt != ADPC_PW_LIGHT)
        else $error("light state used without support");
    light_keeps_a: assert property ( // RULE_06
        ctx_retain_o |-> !ctx_lost_o && (paused_o || tgt == ADPC_PW_FULL))
        else $error("light state lost context");
    open_up_a: assert property ( // RULE_07
        (fsm == ADPC_FS_STABLE && cur == ADPC_PW_OFF && cmd_open_i && !cmd_pwr_down_i
         && !cmd_close_i && !cmd_pause_i && !cmd_resume_i && !open_o && !paused_o)
        |=> fsm == ADPC_FS_MOVE && tgt == ADPC_PW_FULL && open_o && cmd_ack_o)
        else $error("open from off did not power up");
    pause_dest_a: assert property ( // RULE_08
        $rose(paused_o) |-> tgt == (D1_CAP ? ADPC_PW_LIGHT : ADPC_PW_DEEP))
        else $error("pause went to wrong state");
    pause_gate_a: assert property ( // RULE_15
        $rose(paused_o) |-> $past(play_en_o || rec_fg_en_o) && !$past(bg_live))
        else $error("pause accepted without eligible stream");
    resume_a: assert property ( // RULE_09
        $fell(paused_o) |-> tgt == ADPC_PW_FULL && fsm == ADPC_FS_MOVE
        && bounded == (cur != ADPC_PW_OFF))
        else $error("resume did not head to full-on");
    close_timer_a: assert property ( // RULE_10
        $fell(open_o) && !$past(cmd_pwr_down_i) |-> tgt == ADPC_PW_DEEP && inact_run_o)
        else $error("close did not start inactivity timer");
    inact_off_a: assert property ( // RULE_11
        (fsm == ADPC_FS_STABLE && cur == ADPC_PW_DEEP && pend_eff && !open_o && !paused_o
         && !any_cmd) |=> tgt == ADPC_PW_OFF && fsm == ADPC_FS_MOVE)
        else $error("inactivity expiry ignored");
    bg_down_a: assert property ( // RULE_12
        (fsm == ADPC_FS_STABLE && cur == ADPC_PW_FULL && cmd_pwr_down_i && bg_live)
        |=> tgt == ADPC_PW_OFF ##1 busy_o) else $error("background power-down not taken");
    down_refuse_a: assert property ( // RULE_13
        (fsm == ADPC_FS_STABLE && cur == ADPC_PW_FULL && cmd_pwr_down_i && !bg_live)
        |=> cmd_reject_o && cur == ADPC_PW_FULL && !busy_o) else $error("power-down not refused");
    save_first_a: assert property ( // RULE_14
        (fsm == ADPC_FS_MOVE && tgt == ADPC_PW_OFF && $changed(tgt) && paused_o)
        |-> $past(fsm) == ADPC_FS_SAVE && $past(ctx_save_ack_i)) else $error("off without save");
    preempt_a: assert property ( // RULE_17
        rec_bg_en_o |-> !play_en_o && !rec_fg_en_o) else $error("background not preempted");
    wake_gate_a: assert property ( // RULE_18
        wake_o |-> $past(wake_en_i) && $past(cur) != ADPC_PW_FULL) else $error("stray wake");

    pause_resume_c: cover property ($rose(paused_o) ##[1:200] $fell(paused_o));
    bg_off_c: cover property (bg_live && cmd_pwr_down_i ##1 tgt == ADPC_PW_OFF);
    close_off_c: cover property ($fell(open_o) ##[1:1000] power_off_o);
    save_c: cover property (ctx_save_req_o ##1 !ctx_save_req_o);
endmodule
`default_nettype wire

// *** adpc_reg_model.sv ***
`default_nettype none
module adpc_reg_model (
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    input  wire logic       stall_i,
    input  wire logic [1:0] req_i,
    output logic [1:0]      rail_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] stage;
    // regulator settles two cycles after a request; a stall holds the old level
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            stage  <= 2'h3;
            rail_o <= 2'h3;
        end else if (!stall_i) begin
            stage  <= req_i;
            rail_o <= stage;
        end
    end
endmodule
`default_nettype wire

// *** tb_top.sv ***
`default_nettype none
module tb_top import adpc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LAT = 50;
    logic       clock_i, sys_rst_i, save_ack, alarm, wake_en, stall, play, fg, bg;
    logic [4:0] cmd;
    logic [1:0] rail, pwr_state_o, pwr_req_o;
    logic       busy_o, power_off_o, ctx_retain_o, ctx_lost_o, sample_drop_ok_o;
    logic       ctx_save_req_o, paused_o, play_en_o, rec_fg_en_o, rec_bg_en_o;
    logic       cmd_ack_o, cmd_reject_o, lat_fault_o, inact_run_o, wake_o;
    int         miscompares, checks_done, i;
    ////////////////////////////////////////////////////////////////////////////
    adpc_ctrl #(.D1_CAP(1'b1), .LAT_MAX_CYC(LAT), .INACT_CYC(20)) adpc_ctrl_i (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
        .cmd_open_i(cmd[0]), .cmd_close_i(cmd[1]), .cmd_pause_i(cmd[2]),
        .cmd_resume_i(cmd[3]), .cmd_pwr_down_i(cmd[4]), .play_req_i(play),
        .rec_fg_req_i(fg), .rec_bg_req_i(bg), .ctx_save_ack_i(save_ack),
        .rail_lvl_i(rail), .alarm_i(alarm), .wake_en_i(wake_en),
        .pwr_state_o(pwr_state_o), .pwr_req_o(pwr_req_o), .busy_o(busy_o),
        .power_off_o(power_off_o), .ctx_retain_o(ctx_retain_o), .ctx_lost_o(ctx_lost_o),
        .sample_drop_ok_o(sample_drop_ok_o), .ctx_save_req_o(ctx_save_req_o),
        .open_o(), .paused_o(paused_o), .play_en_o(play_en_o), .rec_fg_en_o(rec_fg_en_o),
        .rec_bg_en_o(rec_bg_en_o), .duplex_o(), .cmd_ack_o(cmd_ack_o),
        .cmd_reject_o(cmd_reject_o), .lat_fault_o(lat_fault_o),
        .inact_run_o(inact_run_o), .wake_o(wake_o));
    adpc_reg_model adpc_reg_model_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .stall_i(stall), .req_i(pwr_req_o), .rail_o(rail));
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [1:0] e, input logic [1:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic send(input int b, input logic e);
        @(posedge clock_i) cmd[b] <= 1'b1;
        @(posedge clock_i) cmd <= 5'h0;
        #1 chk("cmd_ack_o", {1'b0, e}, {1'b0, cmd_ack_o});
        chk("cmd_reject_o", {1'b0, !e}, {1'b0, cmd_reject_o});
    endtask
    task automatic wait_st(input adpc_pwr_t s, input int lim);
        for (i = 0; i < lim; i++) begin
            @(posedge clock_i) #1;
            if (busy_o === 1'b0 && pwr_state_o === s) break;
        end
        checks_done++;
        if (i == lim) begin
            $display("unexpected pwr_state_o expected %0h seen %0h", s, pwr_state_o);
            miscompares++;
            final_report();
        end
    endtask
    task automatic grant(input logic p, input logic f, input logic g);
        @(posedge clock_i) play <= p;
        fg <= f;
        bg <= g;
        repeat (3) @(posedge clock_i);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_open();
        chk("pwr_state_o", ADPC_PW_OFF, pwr_state_o);
        chk("power_off_o", 2'h1, {1'b0, power_off_o});
        send(0, 1'b1);
        wait_st(ADPC_PW_FULL, 300);
        chk("ctx_lost_o", 2'h0, {1'b0, ctx_lost_o});
        $display("t_open done");
    endtask
    task automatic t_pause();
        grant(1'b1, 1'b0, 1'b0);
        chk("play_en_o", 2'h1, {1'b0, play_en_o});
        send(2, 1'b1);
        chk("pwr_req_o", ADPC_PW_LIGHT, pwr_req_o);
        chk("paused_o", 2'h1, {1'b0, paused_o});
        send(3, 1'b0);
        wait_st(ADPC_PW_LIGHT, LAT);
        chk("ctx_retain_o", 2'h1, {1'b0, ctx_retain_o});
        chk("sample_drop_ok_o", 2'h0, {1'b0, sample_drop_ok_o});
        send(3, 1'b1);
        wait_st(ADPC_PW_FULL, LAT);
        grant(1'b1, 1'b0, 1'b0);
        chk("play_en_o", 2'h1, {1'b0, play_en_o});
        $display("t_pause done");
    endtask
    task automatic t_bg();
        grant(1'b0, 1'b0, 1'b1);
        chk("rec_bg_en_o", 2'h1, {1'b0, rec_bg_en_o});
        send(2, 1'b0);
        grant(1'b0, 1'b1, 1'b1);
        chk("rec_bg_en_o", 2'h0, {1'b0, rec_bg_en_o});
        chk("rec_fg_en_o", 2'h1, {1'b0, rec_fg_en_o});
        send(4, 1'b0);
        grant(1'b0, 1'b0, 1'b1);
        send(4, 1'b1);
        wait_st(ADPC_PW_OFF, 300);
        chk("power_off_o", 2'h1, {1'b0, power_off_o});
        grant(1'b0, 1'b0, 1'b0);
        $display("t_bg done");
    endtask
    task automatic t_close();
        send(0, 1'b1);
        wait_st(ADPC_PW_FULL, 300);
        send(1, 1'b1);
        chk("inact_run_o", 2'h1, {1'b0, inact_run_o});
        wait_st(ADPC_PW_DEEP, LAT);
        chk("sample_drop_ok_o", 2'h1, {1'b0, sample_drop_ok_o});
        chk("ctx_lost_o", 2'h1, {1'b0, ctx_lost_o});
        wait_st(ADPC_PW_OFF, 60);
        $display("t_close done");
    endtask
    task automatic t_wake();
        @(posedge clock_i) wake_en <= 1'b1;
        alarm <= 1'b1;
        for (i = 0; i < 12 && wake_o !== 1'b1; i++) @(posedge clock_i) #1;
        chk("wake_o", 2'h1, {1'b0, wake_o});
        alarm <= 1'b0;
        $display("t_wake done");
    endtask
    task automatic t_save();
        send(0, 1'b1);
        wait_st(ADPC_PW_FULL, 300);
        grant(1'b1, 1'b0, 1'b0);
        send(2, 1'b1);
        wait_st(ADPC_PW_LIGHT, LAT);
        send(4, 1'b1);
        chk("ctx_save_req_o", 2'h1, {1'b0, ctx_save_req_o});
        repeat (3) @(posedge clock_i);
        #1 chk("pwr_state_o", ADPC_PW_LIGHT, pwr_state_o);
        @(posedge clock_i) save_ack <= 1'b1;
        @(posedge clock_i) save_ack <= 1'b0;
        wait_st(ADPC_PW_OFF, 300);
        chk("ctx_save_req_o", 2'h0, {1'b0, ctx_save_req_o});
        $display("t_save done");
    endtask
    task automatic t_lat();
        send(3, 1'b1);
        wait_st(ADPC_PW_FULL, 300);
        grant(1'b1, 1'b0, 1'b0);
        @(posedge clock_i) stall <= 1'b1;
        send(2, 1'b1);
        for (i = 0; i < LAT + 10 && lat_fault_o !== 1'b1; i++) @(posedge clock_i) #1;
        chk("lat_fault_o", 2'h1, {1'b0, lat_fault_o});
        chk("lat_fault_late", 2'h1, {1'b0, i >= LAT - 2});
        @(posedge clock_i) stall <= 1'b0;
        wait_st(ADPC_PW_LIGHT, 20);
        send(3, 1'b1);
        wait_st(ADPC_PW_FULL, LAT);
        $display("t_lat done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    initial begin
        {sys_rst_i, save_ack, alarm, wake_en, stall, play, fg, bg} = 8'h80;
        cmd = 5'h0;
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        #1;
        t_open();
        t_pause();
        t_bg();
        t_close();
        t_wake();
        t_save();
        t_lat();
        final_report();
    end
endmodule
`default_nettype wire
